/* File: rtl/rims_top.sv */
/*
  Interrupt status and mask logic of the reader front end, with an APB slave.
  Assumes events arrive as one-cycle pulses on pclk from the coder, and that
  the enable pin is already synchronised to pclk.
*/
// Added by the designer: the APB register port.
`timescale 1ns/1ps
//
// Behaviour
// - Flags clear at reset, enable low, control write
// - Rephase end clears flags and interrupt line
// - TX flag at start, interrupt at end
// - RX flag at SOF, interrupt at end
// - FIFO threshold crossing sets bit 5
// - CRC error only without no-CRC option
// - Parity error sets bit 3
// - Framing or EOF error sets bit 2
// - Collision sets bit 1
// - No-response timeout sets bit 0
// - Reading flags clears them and line
// - During TX only bits 5,7 change, except any bit on an end-pulse cycle
// - During RX only bit 6 changes, no interrupt, except on an end-pulse cycle
// - Line rises at end of TX and RX
// - Error and FIFO events gated by enables
// - Enables reset to 3E
// - Collision bits 9:8 in enable register, read-clear
// - Collision bits 7:0 register, read-clear
module rims_top (
  // APB
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Device controls
  input  wire logic                   chip_enable,
  input  wire logic                   no_rx_crc,
  input  wire rims_pkg::rims_evt_s    evt,
  // Outputs
  output logic                        irq_line,
  output logic                        decoder_enable,
  output logic                        irq
);
  import rims_pkg::*;

  rims_state_s r_reg;
  rims_state_s r_next;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction

  logic       setup;
  logic       rd;
  logic       wr;
  logic [7:0] set_f;
  logic [7:0] allow;
  logic [5:0] gated;
  logic       end_evt;
  logic [3:0] sset;

  always_comb begin
    r_next  = r_reg;
    setup   = psel && !penable;
    rd      = setup && !pwrite;
    wr      = setup && pwrite;
    set_f   = 8'h00;
    allow   = 8'hFF;
    sset    = 4'h0;
    end_evt = evt.tx_end || evt.rx_end;

    // Phase tracking
    case (r_reg.phase)
      PH_IDLE: begin
        if (evt.tx_start) begin
          r_next.phase = PH_TX;
        end else if (evt.rx_sof) begin
          r_next.phase = PH_RX;
        end
      end
      PH_TX: begin
        if (evt.tx_end) begin
          r_next.phase = PH_IDLE;
        end
      end
      PH_RX: begin
        if (evt.rx_end) begin
          r_next.phase = PH_IDLE;
        end
      end
      default: r_next.phase = PH_IDLE;
    endcase
    r_next.decoder_en = (r_next.phase != PH_TX);

    if (r_reg.phase == PH_TX) begin
      allow = 8'hA0;
    end else if (r_reg.phase == PH_RX) begin
      allow = 8'h40;
    end

    set_f[BIT_TX]     = evt.tx_start;
    set_f[BIT_SRX]    = evt.rx_sof;
    set_f[BIT_FIFO]   = evt.fifo_level;
    set_f[BIT_CRC]    = evt.crc_err && !no_rx_crc;
    set_f[BIT_PAR]    = evt.parity_err;
    set_f[BIT_FRAME]  = evt.framing_err;
    set_f[BIT_COL]    = evt.collision;
    set_f[BIT_NORESP] = evt.no_response;
    // Frame end pulses may land on the phase exit edge; let them through
    if (end_evt) begin
      allow = 8'hFF;
    end
    set_f = set_f & allow;

    // Read clears, but a same-cycle event survives
    if (rd && hit(paddr, IDX_EVENT_FLAGS)) begin
      r_next.flags = set_f;
    end else begin
      r_next.flags = r_reg.flags | set_f;
    end

    if (evt.collision) begin
      r_next.col_hi = evt.coll_pos[9:8];
      r_next.col_lo = evt.coll_pos[7:0];
    end else begin
      if (rd && hit(paddr, IDX_ENABLE_COLHI)) begin
        r_next.col_hi = 2'b00;
      end
      if (rd && hit(paddr, IDX_COLL_POS)) begin
        r_next.col_lo = 8'h00;
      end
    end

    if (wr && pstrb[0] && hit(paddr, IDX_ENABLE_COLHI)) begin
      r_next.enables = pwdata[5:0];
    end

    // Line: end events plus enabled flag-setting pulses of this cycle
    gated = set_f[5:0] & r_reg.enables;
    if (rd && hit(paddr, IDX_EVENT_FLAGS)) begin
      r_next.line = end_evt || (|gated);
    end else if (end_evt || (|gated)) begin
      r_next.line = 1'b1;
    end

    // Clearing sources win: rephase end and control write
    if (evt.rephase_done || evt.ctrl_write) begin
      r_next.flags = RST_EVENT_FLAGS;
      r_next.line  = 1'b0;
      sset[SB_CLEARED] = 1'b1;
    end

    sset[SB_TX_END] = evt.tx_end;
    sset[SB_RX_END] = evt.rx_end;
    sset[SB_ERROR]  = |set_f[4:1];
    r_next.sirq     = r_reg.sirq | sset;
    if (wr && pstrb[0] && hit(paddr, IDX_IRQ_STATUS)) begin
      r_next.sirq = (r_reg.sirq & ~pwdata[3:0]) | sset;
    end
    if (wr && pstrb[0] && hit(paddr, IDX_IRQ_MASK)) begin
      r_next.smask = pwdata[3:0];
    end
    r_next.irq = |(r_next.sirq & r_next.smask);

    // APB: answer in the access cycle, one wait-free cycle after setup
    r_next.pready  = setup;
    r_next.pslverr = 1'b0;
    r_next.prdata  = 32'h0000_0000;
    if (setup) begin
      if (hit(paddr, IDX_EVENT_FLAGS)) begin
        r_next.prdata = {24'h00_0000, r_reg.flags};
      end else if (hit(paddr, IDX_ENABLE_COLHI)) begin
        r_next.prdata = {24'h00_0000, r_reg.col_hi, r_reg.enables};
      end else if (hit(paddr, IDX_COLL_POS)) begin
        r_next.prdata = {24'h00_0000, r_reg.col_lo};
      end else if (hit(paddr, IDX_IRQ_CTRL)) begin
        r_next.prdata = {29'h0000_0000, r_reg.phase};
      end else if (hit(paddr, IDX_IRQ_STATUS)) begin
        r_next.prdata = {28'h000_0000, r_reg.sirq};
      end else if (hit(paddr, IDX_IRQ_MASK)) begin
        r_next.prdata = {28'h000_0000, r_reg.smask};
      end else begin
        r_next.pslverr = 1'b1;
      end
    end
    if (!r_reg.pready) begin
      r_next.prdata = r_next.prdata;
    end

    // Enable pin low holds flags, enables, collision position, line and phase at their power-on values
    if (!chip_enable) begin
      r_next.flags   = RST_EVENT_FLAGS;
      r_next.enables = RST_ENABLES;
      r_next.col_hi  = 2'b00;
      r_next.col_lo  = RST_COLL_POS;
      r_next.line    = 1'b0;
      r_next.phase   = PH_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg.phase      <= PH_IDLE;
      r_reg.flags      <= RST_EVENT_FLAGS;
      r_reg.enables    <= RST_ENABLES;
      r_reg.col_hi     <= 2'b00;
      r_reg.col_lo     <= RST_COLL_POS;
      r_reg.line       <= 1'b0;
      r_reg.sirq       <= 4'h0;
      r_reg.smask      <= RST_IRQ_MASK;
      r_reg.irq        <= 1'b0;
      r_reg.prdata     <= 32'h0000_0000;
      r_reg.pready     <= 1'b0;
      r_reg.pslverr    <= 1'b0;
      r_reg.decoder_en <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata         = r_reg.prdata;
  assign pready         = r_reg.pready;
  assign pslverr        = r_reg.pslverr;
  assign irq_line       = r_reg.line;
  assign decoder_enable = r_reg.decoder_en;
  assign irq            = r_reg.irq;

endmodule

/* File: inc/rims_pkg.sv */
/*
  Package for the reader interrupt status and mask block: register offsets,
  bit positions, reset values and the state carriers.
  Assumes a 32-bit APB with one aligned word per register.
*/
package rims_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_EVENT_FLAGS  = 8'h0C;
  localparam logic [7:0]  IDX_ENABLE_COLHI = 8'h0D;
  localparam logic [7:0]  IDX_COLL_POS     = 8'h0E;
  localparam logic [7:0]  IDX_IRQ_CTRL     = 8'h20;
  localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h21;
  localparam logic [7:0]  IDX_IRQ_MASK     = 8'h22;

  // Event flag bit positions
  localparam int          BIT_TX     = 7;
  localparam int          BIT_SRX    = 6;
  localparam int          BIT_FIFO   = 5;
  localparam int          BIT_CRC    = 4;
  localparam int          BIT_PAR    = 3;
  localparam int          BIT_FRAME  = 2;
  localparam int          BIT_COL    = 1;
  localparam int          BIT_NORESP = 0;

  // Reset values
  localparam logic [7:0]  RST_EVENT_FLAGS = 8'h00;
  localparam logic [5:0]  RST_ENABLES     = 6'h3E;
  localparam logic [7:0]  RST_COLL_POS    = 8'h00;
  localparam logic [3:0]  RST_IRQ_MASK    = 4'h0;

  // Own interrupt status bits (sticky, write one to clear)
  localparam int          SB_TX_END  = 0;
  localparam int          SB_RX_END  = 1;
  localparam int          SB_ERROR   = 2;
  localparam int          SB_CLEARED = 3;

  // Frame-side events from the coder
  typedef struct packed {
    logic       tx_start;
    logic       tx_end;
    logic       rx_sof;
    logic       rx_end;
    logic       fifo_level;
    logic       crc_err;
    logic       parity_err;
    logic       framing_err;
    logic       collision;
    logic       no_response;
    logic       rephase_done;
    logic       ctrl_write;
    logic [9:0] coll_pos;
  } rims_evt_s;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_TX   = 3'b010,
    PH_RX   = 3'b100
  } rims_phase_e;

  typedef struct packed {
    rims_phase_e phase;
    logic [7:0]  flags;
    logic [5:0]  enables;
    logic [1:0]  col_hi;
    logic [7:0]  col_lo;
    logic        line;
    logic [3:0]  sirq;
    logic [3:0]  smask;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        decoder_en;
  } rims_state_s;

endpackage

/* File: tb/rims_props.sv */
/* Port checker for the interrupt status block.
   Assumes it is bound to rims_top and sees only its ports. */
`timescale 1ns/1ps
module rims_props (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic                pready,
  // Device
  input wire logic                no_rx_crc,
  input wire logic                chip_enable,
  input wire rims_pkg::rims_evt_s evt,
  input wire logic                irq_line,
  input wire logic                decoder_enable
);
  import rims_pkg::*;
  logic [11:0] ev;
  logic        src;
  assign ev  = evt[21:10];
  // Only these may launch the line
  assign src = ev[10] | ev[8] | (|ev[7:2]);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  property p_end_irq; chip_enable && (ev[10] || ev[8]) && ev[1:0] == 2'b00 |=> irq_line; endproperty
  a_end_irq: assert property (p_end_irq) else $error("line not raised at frame end");
  property p_clear; ev[1:0] != 2'b00 |=> !irq_line; endproperty
  a_clear: assert property (p_clear) else $error("line kept after clear event");
  property p_off; !chip_enable |=> !irq_line; endproperty
  a_off: assert property (p_off) else $error("line high while disabled");
  property p_tx_quiet; ev == 12'h800 && !irq_line |=> !irq_line; endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("line raised at tx start");
  property p_rx_quiet; ev == 12'h200 && !irq_line |=> !irq_line; endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("line raised at rx start");
  property p_dec_off; chip_enable && ev == 12'h800 |=> !decoder_enable; endproperty
  a_dec_off: assert property (p_dec_off) else $error("decoder on during tx");
  property p_read_clr; psel && !penable && !pwrite && paddr == 12'h030 && ev == 12'h000 |=> !irq_line; endproperty
  a_read_clr: assert property (p_read_clr) else $error("flag read left line high");
  property p_crc_off; no_rx_crc && ev == 12'h040 && !irq_line |=> !irq_line; endproperty
  a_crc_off: assert property (p_crc_off) else $error("crc event seen with crc off");
  property p_cause; $rose(irq_line) |-> $past(src); endproperty
  a_cause: assert property (p_cause) else $error("line rose without a source");
  property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
  a_answer: assert property (p_answer) else $error("access not answered in one cycle");
endmodule
bind rims_top rims_props rims_props_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .no_rx_crc(no_rx_crc), .chip_enable(chip_enable),
  .evt(evt), .irq_line(irq_line), .decoder_enable(decoder_enable));

/* File: tb/rims_coder_model.sv */
/* Coder-side event source: one event pulse per go cycle.
   Assumes go, kind and pos change just after the rising edge. */
`timescale 1ns/1ps
module rims_coder_model (
  // Control
  input  wire logic          go,
  input  wire logic [3:0]    kind,
  input  wire logic [9:0]    pos,
  // Events
  output rims_pkg::rims_evt_s evt
);
  import rims_pkg::*;
  // Position only meaningful with collision; otherwise garbage
  assign evt = {(go ? 12'h800 >> kind : 12'h000), (go ? pos : ~pos)};
endmodule

/* File: tb/rfid_reader_irq_status_mask_test.sv */
/* Self-checking bench for the interrupt status and mask block.
   Assumes the coder model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module rfid_reader_irq_status_mask_test;
  import rims_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, irq_line, decoder_enable, irq;
  logic        chip_enable = 1'b1, no_rx_crc = 1'b0, go = 1'b0;
  logic [3:0]  kind = 4'h0;
  logic [9:0]  pos = 10'h000;
  logic [7:0]  exp;
  logic [5:0]  mask;
  rims_evt_s   evt;
  int          seed = 32'h7f3ec89c;
  int          n_fail = 0;
  int          samples_checked = 0;
  always #25 pclk = ~pclk;
  rims_coder_model rims_coder_model_i (.go(go), .kind(kind), .pos(pos), .evt(evt));
  rims_top rims_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_enable(chip_enable), .no_rx_crc(no_rx_crc), .evt(evt), .irq_line(irq_line),
    .decoder_enable(decoder_enable), .irq(irq));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at the answer away from the edge that launches it
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) n_fail++;
    rd  = prdata;
    err = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, want);
  endtask
  task automatic pulse(input logic [3:0] k);
    @(posedge pclk);
    go   <= 1'b1;
    kind <= k;
    pos  <= 10'($random(seed));
    @(posedge pclk);
    go <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #250000;
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("flags", 12'h030, 32'h0);
    rdchk("enables", 12'h034, 32'h3E);
    rdchk("colpos", 12'h038, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    $display("test reset done");
    apb(1'b1, 12'h088, 32'h1);
    pulse(4'd0);
    chk("line tx", 32'(irq_line), 32'h0);
    chk("dec tx", 32'(decoder_enable), 32'h0);
    rdchk("phase", 12'h080, 32'h2);
    pulse(4'd2);
    pulse(4'd6);
    pulse(4'd1);
    chk("line txend", 32'(irq_line), 32'h1);
    chk("irq txend", 32'(irq), 32'h1);
    rdchk("sirq txend", 12'h084, 32'h1);
    apb(1'b1, 12'h084, 32'hF);
    chk("irq w1c", 32'(irq), 32'h0);
    rdchk("flags tx", 12'h030, 32'h80);
    pulse(4'd2);
    pulse(4'd5);
    chk("line rx", 32'(irq_line), 32'h0);
    pulse(4'd3);
    chk("line rxend", 32'(irq_line), 32'h1);
    rdchk("flags rx", 12'h030, 32'h40);
    $display("test frames done");
    pulse(4'd6);
    pulse(4'd11);
    chk("line ctrl", 32'(irq_line), 32'h0);
    rdchk("flags ctrl", 12'h030, 32'h0);
    pulse(4'd7);
    pulse(4'd10);
    chk("line rephase", 32'(irq_line), 32'h0);
    rdchk("flags rephase", 12'h030, 32'h0);
    apb(1'b1, 12'h034, 32'h0);
    pulse(4'd7);
    chk("line masked", 32'(irq_line), 32'h0);
    @(posedge pclk);
    chip_enable <= 1'b0;
    @(posedge pclk);
    chip_enable <= 1'b1;
    rdchk("enables off", 12'h034, 32'h3E);
    rdchk("flags off", 12'h030, 32'h0);
    $display("test clears done");
    for (int p = 0; p < 2; p++) begin
      mask = p ? 6'($random(seed)) : 6'h3E;
      @(posedge pclk);
      no_rx_crc <= p ? 1'($random(seed)) : 1'b0;
      apb(1'b1, 12'h034, {26'h0, mask});
      for (int k = 4; k < 10; k++) begin
        pulse(4'(k));
        exp = 8'h20 >> (k - 4);
        if (k == 5 && no_rx_crc) exp = 8'h00;
        chk("line", 32'(irq_line), 32'(|(exp[5:0] & mask)));
        rdchk("flags", 12'h030, 32'(exp));
        chk("line clr", 32'(irq_line), 32'h0);
        if (k == 8) begin
          rdchk("colhi", 12'h034, {24'h0, pos[9:8], mask});
          rdchk("colhi clr", 12'h034, {26'h0, mask});
          rdchk("collo", 12'h038, 32'(pos[7:0]));
          rdchk("collo clr", 12'h038, 32'h0);
        end
      end
      $display("test sources pass done");
    end
    finish_test;
  end
endmodule
